// file: hdl/bit_read_server.sv
// Responder for coil and discrete-input reads over a framed byte stream
//
// Behaviour
// - Protocol identifier bytes are zero both ways.
// - Length field counts following bytes; request six.
// - Unit address 1..247 and equals configured address.
// - Function two returns discrete input states.
// - Coil read above 100 bits is invalid.
// - Node coil base address is (id-1)*2.
// - Input read above 200 bits is invalid.
// - Node input base address is (id-1)*4.
// - Eight bits per byte, lower address first.
// - Byte-count field precedes the returned data.
// - Response echoes unit address and function code.
`timescale 1ns/1ns
module bit_read_server
   import bit_read_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] unitAddr,
   input wire logic [COIL_BITS-1:0] coilState,
   input wire logic [INPUT_BITS-1:0] inputState,
   input wire rx_byte_t rxIn,
   output logic rxReady,
   output logic [7:0] txByte,
   output logic txValid,
   output logic txLast,
   input wire logic txReady
);
   state_t st_r;
   state_t st_nxt;
   logic rxTake;
   logic txFree;
   logic [15:0] qtyFull;
   logic [16:0] endAddr;
   logic [16:0] maxQty;
   logic [7:0] dataByte;
   logic [7:0] rspLen;
   logic [INPUT_BITS-1:0] bitTable;
   logic [5:0] dataIdx;

   assign rxTake = rxIn.valid && st_r.rxReady;
   assign txFree = !st_r.txValid || txReady;
   assign qtyFull = {st_r.qtyHi, rxIn.data};
   assign endAddr = {1'b0, st_r.start} + {1'b0, qtyFull};
   assign maxQty = (st_r.func == FUNC_COILS) ? COIL_MAX_QTY
                                             : INPUT_MAX_QTY;
   assign rspLen = RSP_LEN_BASE + ((st_r.excCode != 8'h00) ? 8'h00
                   : {2'b00, st_r.txLen - RSP_HDR_BYTES});
   assign dataIdx = st_r.txIdx - RSP_HDR_BYTES;

   // -------------------------------------------------------------------
   // Bit table
   // -------------------------------------------------------------------
   // Node n owns bits (n-1)*2 .. +1 of coilState and (n-1)*4 .. +3 of
   // inputState, so a table index equals the protocol bit address.
   always_comb begin
      bitTable = '0;
      if (st_r.func == FUNC_COILS) begin
         bitTable[COIL_BITS-1:0] = coilState;
      end else begin
         bitTable = inputState;
      end
   end

   // -------------------------------------------------------------------
   // Data byte packing
   // -------------------------------------------------------------------
   // Bit 0 of each byte holds the lowest address; bits past the quantity
   // are sent as zero.
   generate
      for (genvar b = 0; b < BITS_PER_BYTE; b++) begin : g_pack
         logic [16:0] relPos;
         logic [16:0] absPos;
         assign relPos = {8'h00, dataIdx, 3'(b)};
         assign absPos = {1'b0, st_r.start} + relPos;
         assign dataByte[b] = (relPos < {1'b0, st_r.qty})
                              && (absPos < 17'(INPUT_BITS))
                              && bitTable[absPos[7:0]];
      end
   endgenerate

   // -------------------------------------------------------------------
   // Response byte at index
   // -------------------------------------------------------------------
   function automatic logic [7:0] rspByte(input logic [5:0] idx);
      logic [7:0] val;
      val = dataByte;
      unique case (idx)
         6'h00: val = st_r.transId[15:8];
         6'h01: val = st_r.transId[7:0];
         6'h02: val = PROTO_ID[15:8];
         6'h03: val = PROTO_ID[7:0];
         6'h04: val = 8'h00;
         6'h05: val = rspLen;
         6'h06: val = st_r.unit;
         6'h07: begin
            val = (st_r.excCode != 8'h00) ? (st_r.func | FUNC_EXC_FLAG)
                                          : st_r.func;
         end
         6'h08: begin
            val = (st_r.excCode != 8'h00) ? st_r.excCode
                  : {2'b00, st_r.txLen - RSP_HDR_BYTES};
         end
         default: val = dataByte;
      endcase
      return val;
   endfunction : rspByte

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      unique case (st_r.mode)
         RECEIVE, DISCARD: begin
            st_nxt.rxReady = 1'b1;
            if (rxTake) begin
               if (rxIn.first) begin
                  st_nxt.rxIdx = 4'h1;
                  st_nxt.hdrOk = 1'b1;
                  st_nxt.mode = RECEIVE;
                  st_nxt.transId[15:8] = rxIn.data;
               end else if (st_r.mode == RECEIVE) begin
                  st_nxt.rxIdx = st_r.rxIdx + 4'h1;
                  unique case (st_r.rxIdx)
                     4'h0: st_nxt.transId[15:8] = rxIn.data;
                     4'h1: st_nxt.transId[7:0] = rxIn.data;
                     4'h2, 4'h3: begin
                        if (rxIn.data != 8'h00) begin
                           st_nxt.hdrOk = 1'b0;
                        end
                     end
                     4'h4: begin
                        if (rxIn.data != REQ_LENGTH[15:8]) begin
                           st_nxt.hdrOk = 1'b0;
                        end
                     end
                     4'h5: begin
                        if (rxIn.data != REQ_LENGTH[7:0]) begin
                           st_nxt.hdrOk = 1'b0;
                        end
                     end
                     IDX_UNIT: begin
                        st_nxt.unit = rxIn.data;
                        if (rxIn.data < UNIT_MIN || rxIn.data > UNIT_MAX
                            || rxIn.data != unitAddr) begin
                           st_nxt.hdrOk = 1'b0;
                        end
                     end
                     IDX_FUNC: st_nxt.func = rxIn.data;
                     IDX_START_HI: st_nxt.start[15:8] = rxIn.data;
                     IDX_START_LO: st_nxt.start[7:0] = rxIn.data;
                     IDX_QTY_HI: st_nxt.qtyHi = rxIn.data;
                     REQ_LAST_IDX: begin
                        st_nxt.qty = qtyFull;
                        st_nxt.rxIdx = 4'h0;
                        st_nxt.excCode = 8'h00;
                        st_nxt.txLen = RSP_HDR_BYTES;
                        if (st_r.func != FUNC_COILS
                            && st_r.func != FUNC_INPUTS) begin
                           st_nxt.excCode = EXC_BAD_FUNC;
                        end else if (qtyFull == 16'h0000
                                     || {1'b0, qtyFull} > maxQty) begin
                           st_nxt.excCode = EXC_BAD_QTY;
                        end else if (endAddr > maxQty) begin
                           st_nxt.excCode = EXC_BAD_ADDR;
                        end else begin
                           st_nxt.txLen = RSP_HDR_BYTES
                              + 6'((qtyFull + 16'h0007) >> 3);
                        end
                        if (st_r.hdrOk) begin
                           st_nxt.mode = SEND;
                           st_nxt.rxReady = 1'b0;
                           st_nxt.txIdx = 6'h00;
                        end
                     end
                     default: st_nxt.mode = DISCARD;
                  endcase
               end
            end
         end
         SEND: begin
            // Input stalls while answering; one request in flight
            st_nxt.rxReady = 1'b0;
            if (txFree) begin
               if (st_r.txIdx == st_r.txLen) begin
                  st_nxt.txValid = 1'b0;
                  st_nxt.txLast = 1'b0;
                  st_nxt.mode = RECEIVE;
                  st_nxt.rxReady = 1'b1;
               end else begin
                  st_nxt.txByte = rspByte(st_r.txIdx);
                  st_nxt.txValid = 1'b1;
                  st_nxt.txLast = (st_r.txIdx + 6'h01) == st_r.txLen;
                  st_nxt.txIdx = st_r.txIdx + 6'h01;
               end
            end
         end
         default: st_nxt = STATE_RESET;
      endcase
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rxReady = st_r.rxReady;
   assign txByte = st_r.txByte;
   assign txValid = st_r.txValid;
   assign txLast = st_r.txLast;
endmodule : bit_read_server

// file: hdl/bit_read_pkg.sv
// Constants and carrier types for the bit-read protocol responder
package bit_read_pkg;
   // -------------------------------------------------------------------
   // Frame layout
   // -------------------------------------------------------------------
   localparam logic [3:0] REQ_LAST_IDX = 4'hB;
   localparam logic [3:0] IDX_UNIT = 4'h6;
   localparam logic [3:0] IDX_FUNC = 4'h7;
   localparam logic [3:0] IDX_START_HI = 4'h8;
   localparam logic [3:0] IDX_START_LO = 4'h9;
   localparam logic [3:0] IDX_QTY_HI = 4'hA;
   localparam logic [5:0] RSP_HDR_BYTES = 6'h09;
   localparam logic [15:0] PROTO_ID = 16'h0000;
   localparam logic [15:0] REQ_LENGTH = 16'h0006;
   localparam logic [7:0] RSP_LEN_BASE = 8'h03;
   // -------------------------------------------------------------------
   // Addressing and limits
   // -------------------------------------------------------------------
   localparam logic [7:0] UNIT_MIN = 8'h01;
   localparam logic [7:0] UNIT_MAX = 8'hF7;
   localparam logic [7:0] FUNC_COILS = 8'h01;
   localparam logic [7:0] FUNC_INPUTS = 8'h02;
   localparam logic [7:0] FUNC_EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_BAD_QTY = 8'h03;
   localparam int NODE_COUNT = 50;
   localparam int COILS_PER_NODE = 2;
   localparam int INPUTS_PER_NODE = 4;
   localparam int COIL_BITS = NODE_COUNT * COILS_PER_NODE;
   localparam int INPUT_BITS = NODE_COUNT * INPUTS_PER_NODE;
   localparam logic [16:0] COIL_MAX_QTY = 17'h00064;
   localparam logic [16:0] INPUT_MAX_QTY = 17'h000C8;
   localparam int BITS_PER_BYTE = 8;
   localparam int MAX_DATA_BYTES = 25;
   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      RECEIVE,
      DISCARD,
      SEND
   } mode_t;

   typedef struct packed {
      logic valid;
      logic first;
      logic [7:0] data;
   } rx_byte_t;

   typedef struct packed {
      mode_t mode;
      logic [3:0] rxIdx;
      logic [15:0] transId;
      logic hdrOk;
      logic [7:0] unit;
      logic [7:0] func;
      logic [15:0] start;
      logic [7:0] qtyHi;
      logic [15:0] qty;
      logic [7:0] excCode;
      logic [5:0] txIdx;
      logic [5:0] txLen;
      logic [7:0] txByte;
      logic txValid;
      logic txLast;
      logic rxReady;
   } state_t;

   localparam state_t STATE_RESET = '{
      mode: RECEIVE, rxIdx: 4'h0, transId: 16'h0000, hdrOk: 1'b1,
      unit: 8'h00, func: 8'h00, start: 16'h0000, qtyHi: 8'h00,
      qty: 16'h0000, excCode: 8'h00, txIdx: 6'h00, txLen: 6'h00,
      txByte: 8'h00, txValid: 1'b0, txLast: 1'b0, rxReady: 1'b0
   };
endpackage : bit_read_pkg

// file: testbench/bit_read_server_checker.sv
// Port-level assertions for the bit-read responder
`timescale 1ns/1ns
module bit_read_server_checker
   import bit_read_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic rxReady,
   input wire logic [7:0] txByte,
   input wire logic txValid,
   input wire logic txLast,
   input wire logic txReady
);
   logic [5:0] txCnt_r;
   logic [7:0] txLen_r;
   logic [7:0] txFunc_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Byte position inside the response, for field checks
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         txCnt_r <= 6'h00;
         txLen_r <= 8'h00;
         txFunc_r <= 8'h00;
      end else if (txValid && txReady) begin
         txCnt_r <= txLast ? 6'h00 : txCnt_r + 6'h01;
         if (txCnt_r == 6'h05) txLen_r <= txByte;
         if (txCnt_r == 6'h07) txFunc_r <= txByte;
      end
   end
   sequence s_lastTaken;
      txValid && txLast && txReady;
   endsequence
   property p_txHold;
      txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast);
   endproperty
   a_txHold: assert property (p_txHold) else $error("byte dropped");
   property p_lastValid;
      txLast |-> txValid;
   endproperty
   a_lastValid: assert property (p_lastValid) else $error("stray last");
   property p_rxBlocked;
      txValid |-> !rxReady;
   endproperty
   a_rxBlocked: assert property (p_rxBlocked) else $error("rx open");
   property p_frameEnd;
      s_lastTaken |=> !txValid && rxReady;
   endproperty
   a_frameEnd: assert property (p_frameEnd) else $error("no idle");
   property p_fixedZero;
      txValid && txCnt_r inside {6'h02, 6'h03, 6'h04} |-> txByte == 8'h00;
   endproperty
   a_fixedZero: assert property (p_fixedZero) else $error("nonzero");
   property p_lastAtLen;
      txValid && txLast |-> txCnt_r == txLen_r[5:0] + 6'h05;
   endproperty
   a_lastAtLen: assert property (p_lastAtLen) else $error("bad len");
   property p_byteCount;
      txValid && txCnt_r == 6'h08 && !txFunc_r[7]
         |-> txLen_r == txByte + 8'h03;
   endproperty
   a_byteCount: assert property (p_byteCount) else $error("bad count");
   property p_exception;
      txValid && txCnt_r == 6'h08 && txFunc_r[7]
         |-> txLast && txLen_r == 8'h03 && txByte inside {8'h01, 8'h02, 8'h03};
   endproperty
   a_exception: assert property (p_exception) else $error("bad exc");
   property p_answerSoon;
      $fell(rxReady) |-> ##[0:2] txValid;
   endproperty
   a_answerSoon: assert property (p_answerSoon) else $error("late");
endmodule : bit_read_server_checker

bind bit_read_server bit_read_server_checker i_chk(.clk_sys(clk_sys),
   .reset_n(reset_n), .rxReady(rxReady), .txByte(txByte),
   .txValid(txValid), .txLast(txLast), .txReady(txReady));

// file: testbench/master_station.sv
// Master station model: sends request frames, collects the response
`timescale 1ns/1ns
module master_station
   import bit_read_pkg::*;
(
   input wire logic clk_sys,
   output rx_byte_t rxIn,
   input wire logic rxReady,
   input wire logic [7:0] txByte,
   input wire logic txValid,
   output logic txReady
);
   logic [15:0] tid = 16'h0000;
   logic slow = 1'b0;
   logic [7:0] rsp[$];
   initial rxIn = '0;
   initial txReady = 1'b0;
   // Slow mode stalls every other cycle
   always @(posedge clk_sys) begin
      if (txValid && txReady) rsp.push_back(txByte);
      txReady <= #1 slow ? ~txReady : 1'b1;
   end
   task automatic send_frame(input logic [15:0] pr, ln, input logic [7:0] un,
      fc, input logic [15:0] st, qt);
      logic [7:0] f[12];
      f = '{tid[15:8], tid[7:0], pr[15:8], pr[7:0], ln[15:8], ln[7:0],
         un, fc, st[15:8], st[7:0], qt[15:8], qt[7:0]};
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 12; i++) begin
         rxIn = '{1'b1, i == 0, f[i]};
         do @(posedge clk_sys); while (rxReady !== 1'b1);
         #1;
      end
      rxIn.valid = 1'b0;
      rxIn.data = ~f[11];
      tid = tid + 16'h0001;
   endtask : send_frame
endmodule : master_station

// file: testbench/modbus_tcp_bit_read_server_bench.sv
// Self-checking bench for the bit-read responder
`timescale 1ns/1ns
module modbus_tcp_bit_read_server_bench;
   import bit_read_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] unitAddr = 8'h11;
   logic [COIL_BITS-1:0] coilState;
   logic [INPUT_BITS-1:0] inputState;
   rx_byte_t rxIn;
   logic rxReady, txValid, txLast, txReady;
   logic [7:0] txByte;
   int n_errors = 0;
   int checks = 0;
   always #25 clk_sys = ~clk_sys;
   bit_read_server i_dut(.clk_sys(clk_sys), .reset_n(reset_n),
      .unitAddr(unitAddr), .coilState(coilState), .inputState(inputState),
      .rxIn(rxIn), .rxReady(rxReady), .txByte(txByte), .txValid(txValid),
      .txLast(txLast), .txReady(txReady));
   master_station i_master(.clk_sys(clk_sys), .rxIn(rxIn),
      .rxReady(rxReady), .txByte(txByte), .txValid(txValid),
      .txReady(txReady));
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(logic [15:0] pr, ln, logic [7:0] un, fc,
      logic [15:0] st, qt, bit ans);
      logic [7:0] e[$];
      logic [15:0] tid;
      int mx, ex, nb, k;
      tid = i_master.tid;
      mx = (fc == FUNC_COILS) ? 100 : 200;
      ex = (fc != FUNC_COILS && fc != FUNC_INPUTS) ? 1
         : (qt == 0 || qt > mx) ? 3 : (st + qt > mx) ? 2 : 0;
      nb = (qt + 7) / 8;
      if (ans) begin
         e = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00};
         e.push_back(ex ? 8'h03 : 8'(3 + nb));
         e.push_back(un);
         e.push_back(ex ? fc | FUNC_EXC_FLAG : fc);
         e.push_back(ex ? 8'(ex) : 8'(nb));
         for (k = 0; k < 8 * nb && ex == 0; k++) begin
            if (k % 8 == 0) e.push_back(8'h00);
            if (k < qt) e[e.size()-1][k%8] = (fc == FUNC_COILS)
               ? coilState[st+k] : inputState[st+k];
         end
      end
      i_master.rsp.delete();
      i_master.send_frame(pr, ln, un, fc, st, qt);
      k = 0;
      repeat (3) @(posedge clk_sys);
      while ((rxReady !== 1'b1 || txValid !== 1'b0) && k < 500) begin
         @(posedge clk_sys);
         k++;
      end
      // A response that never ends is a mismatch, not a silent pass
      if (k >= 500) begin
         n_errors++;
         $display("wrong value idle expected 1 seen 0");
      end
      chk("length", e.size(), i_master.rsp.size());
      foreach (e[i]) begin
         if (i < i_master.rsp.size()) chk("byte", e[i], i_master.rsp[i]);
      end
   endtask : xfer
   task automatic t_coil;
      xfer(16'h0000, 16'h0006, 8'h11, 8'h01, 16'h0004, 16'h0002, 1);
      xfer(16'h0000, 16'h0006, 8'h11, 8'h01, 16'h0000, 16'h0064, 1);
      xfer(16'h0000, 16'h0006, 8'h11, 8'h01, 16'h0000, 16'h0065, 1);
      xfer(16'h0000, 16'h0006, 8'h11, 8'h01, 16'h0063, 16'h0002, 1);
   endtask : t_coil
   task automatic t_input;
      xfer(16'h0000, 16'h0006, 8'h11, 8'h02, 16'h0004, 16'h000D, 1);
      xfer(16'h0000, 16'h0006, 8'h11, 8'h02, 16'h0000, 16'h00C8, 1);
      xfer(16'h0000, 16'h0006, 8'h11, 8'h02, 16'h0000, 16'h00C9, 1);
      xfer(16'h0000, 16'h0006, 8'h11, 8'h02, 16'h0001, 16'h0000, 1);
   endtask : t_input
   task automatic t_refuse;
      xfer(16'h0000, 16'h0006, 8'h11, 8'h03, 16'h0000, 16'h0001, 1);
      xfer(16'h0001, 16'h0006, 8'h11, 8'h01, 16'h0000, 16'h0001, 0);
      xfer(16'h0000, 16'h0007, 8'h11, 8'h01, 16'h0000, 16'h0001, 0);
      xfer(16'h0000, 16'h0006, 8'h12, 8'h01, 16'h0000, 16'h0001, 0);
      unitAddr = 8'hF8;
      xfer(16'h0000, 16'h0006, 8'hF8, 8'h01, 16'h0000, 16'h0001, 0);
      unitAddr = 8'hF7;
      xfer(16'h0000, 16'h0006, 8'hF7, 8'h02, 16'h00C4, 16'h0004, 1);
   endtask : t_refuse
   task automatic t_stall;
      i_master.slow = 1'b1;
      xfer(16'h0000, 16'h0006, 8'hF7, 8'h02, 16'h0008, 16'h0018, 1);
      i_master.slow = 1'b0;
   endtask : t_stall
   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   initial begin
      for (int i = 0; i < COIL_BITS; i++) coilState[i] = (i % 3 == 0);
      for (int i = 0; i < INPUT_BITS; i++) inputState[i] = (i % 5 < 2);
      repeat (20) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      t_coil();
      t_input();
      t_refuse();
      t_stall();
      report_and_stop();
   end
   // Roughly fifty times the expected run
   initial begin
      #1000000;
      n_errors++;
      report_and_stop();
   end
endmodule : modbus_tcp_bit_read_server_bench
